// file: rtl/input_front_pkg.sv
package input_front_pkg;
  // -----------------------------------------------------------------
  // sizes
  // -----------------------------------------------------------------
  localparam int          STAGES       = 9;
  localparam int          WORD_MAX     = 8;
  localparam int          LEN_W        = 3;
  localparam int          ADDR_W       = 9;
  localparam int          OUT_W        = 20;
  localparam int          FIRST_STAGE  = 8;
  localparam int          MIDDLE_STAGE = 7;
  localparam int          LAST_STAGE   = 0;
  localparam int          T_PORT_STAGE = 5;
  localparam int          S_PORT_STAGE = 2;
  localparam logic [3:0]  PAR_FILL     = 4'h3;
  // -----------------------------------------------------------------
  // timing
  // -----------------------------------------------------------------
  localparam int          SYS_CLK_MHZ  = 100;
  localparam int          MCLK_MAX_MHZ = 20;
  localparam int          MCLK_MIN_CYC = (SYS_CLK_MHZ + MCLK_MAX_MHZ - 1) / MCLK_MAX_MHZ;
  localparam logic [7:0]  CNT_ZERO     = 8'h00;
  localparam logic [7:0]  CNT_ONE      = 8'h01;
  localparam logic [2:0]  LEN_ZERO     = 3'h0;

  typedef logic [WORD_MAX-1:0] word_t;

  typedef struct packed {
    word_t s_word;
    word_t t_word;
    word_t p_word;
  } in_words_t;

  typedef struct packed {
    logic [LEN_W-1:0] word_length;
    logic             input_path_select;
    logic             signed_data;
    logic             signed_coeffs;
  } config_t;

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_CAPTURE,
    ST_SHIFT,
    ST_DONE
  } ctl_state_t;
endpackage

// file: rtl/input_front.sv
`timescale 1ns/10ps
// Contract
// RULE1 - nine serial bits form memory address
// RULE2 - controller timed only by load, master clock
// RULE3 - three-bit word length sets shift count
// RULE4 - one select line picks 3x3 or 9x1
// RULE5 - master clock square wave below 20 MHz
// RULE6 - load pulse starts serial conversion
// RULE7 - strobe marks valid data, latches it
// RULE8 - signed-data input picks arithmetic kind
// RULE9 - output bus driven only when enabled
// RULE10 - data valid flags completed computation
// RULE11 - short words take sign from coefficient input
// RULE12 - capture on strobe rise, hold until next
// RULE13 - stage takes own input or previous stage
// RULE14 - strobe shifts chain; convert once all loaded
// RULE15 - capture loads serial regs, then shift
// RULE16 - shift phase is capture or phase or supply
// RULE17 - two non-overlapping phases from master clock; shift_phase output is also forced high by capture and programming_supply
// RULE18 - last stage holds bit one cycle, drives address
// RULE19 - programming supply routes data to address
// RULE20 - select high passes first path
// RULE21 - source fills serial in nine, parallel in three
// RULE22 - shift steps equal configured word length
module input_front (
  input  wire logic                                   sys_clk,
  input  wire logic                                   rst_b,
  input  wire input_front_pkg::in_words_t             data_in,
  input  wire logic                                   strobe,
  input  wire logic                                   load,
  input  wire logic                                   master_clock,
  input  wire input_front_pkg::config_t               cfg,
  input  wire logic                                   programming_supply,
  input  wire logic                                   output_enable,
  input  wire logic [input_front_pkg::OUT_W-1:0]      result_in,
  output logic      [input_front_pkg::ADDR_W-1:0]     memory_address,
  output logic                                        memory_write_permit,
  output logic                                        main_phase,
  output logic                                        shift_phase,
  output logic                                        arith_signed,
  output logic                                        sign_fill,
  output logic                                        data_valid,
  output logic      [input_front_pkg::OUT_W-1:0]      out_bus,
  output logic      [input_front_pkg::OUT_W-1:0]      out_bus_oe,
  output logic                                        window_latch_last,
  output logic                                        window_latch_middle,
  output logic                                        window_latch_first
);
  localparam int STAGES = input_front_pkg::STAGES;
  localparam int W      = input_front_pkg::WORD_MAX;
  localparam int T_ST   = input_front_pkg::T_PORT_STAGE;
  localparam int S_ST   = input_front_pkg::S_PORT_STAGE;

  // -----------------------------------------------------------------
  // parameter checks
  // -----------------------------------------------------------------
  initial begin
    if (STAGES != input_front_pkg::ADDR_W) $error("stage count must match address width");
    // the fill and step counters are only four bits wide
    if (STAGES >= 16) $error("stage count exceeds the fill counter");
    if (W >= 16) $error("word width exceeds the step counter");
  end

  // -----------------------------------------------------------------
  // edge detection on user inputs
  // -----------------------------------------------------------------
  logic strobe_q, load_q, mclk_q;
  logic next_strobe_q, next_load_q, next_mclk_q;
  logic strobe_rise, load_rise, mclk_rise, mclk_fall;

  always_comb begin
    next_strobe_q = strobe;
    next_load_q   = load;
    next_mclk_q   = master_clock;
    strobe_rise   = strobe & ~strobe_q;
    load_rise     = load & ~load_q;
    mclk_rise     = master_clock & ~mclk_q;
    mclk_fall     = ~master_clock & mclk_q;
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_q <= 1'b0;
      load_q   <= 1'b0;
      mclk_q   <= 1'b0;
    end else begin
      strobe_q <= next_strobe_q;
      load_q   <= next_load_q;
      mclk_q   <= next_mclk_q;
    end
  end

  // -----------------------------------------------------------------
  // input latch chain
  // -----------------------------------------------------------------
  logic [W-1:0] latch      [STAGES];
  logic [W-1:0] next_latch [STAGES];
  logic [3:0]   fill;
  logic [3:0]   next_fill;
  logic         all_loaded;

  // first path when select is high, second when low
  function automatic logic [W-1:0] pick(input logic sel, input logic [W-1:0] a,
                                        input logic [W-1:0] b);
    pick = sel ? a : b; // RULE20
  endfunction

  always_comb begin
    for (int i = 0; i < STAGES; i++) begin
      next_latch[i] = latch[i];
    end
    next_fill = fill;
    if (strobe_rise) begin // RULE7 RULE12
      // shift toward stage zero; stages 8, 5, 2 may take an external port
      for (int i = 0; i < STAGES - 1; i++) begin
        next_latch[i] = latch[i+1]; // RULE14
      end
      next_latch[input_front_pkg::FIRST_STAGE] = data_in.p_word;
      // high select = parallel (3x3), low = serial chain (9x1)
      next_latch[T_ST] = pick(cfg.input_path_select, data_in.t_word, latch[T_ST+1]); // RULE13 RULE4
      next_latch[S_ST] = pick(cfg.input_path_select, data_in.s_word, latch[S_ST+1]); // RULE13
      if (fill != 4'(STAGES)) begin
        next_fill = fill + 4'h1;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      for (int i = 0; i < STAGES; i++) begin
        latch[i] <= '0;
      end
      fill <= 4'h0;
    end else begin
      for (int i = 0; i < STAGES; i++) begin
        latch[i] <= next_latch[i];
      end
      fill <= next_fill;
    end
  end

  // parallel mode fills in three strobes, serial in nine
  assign all_loaded = cfg.input_path_select ? (fill >= input_front_pkg::PAR_FILL)
                                            : (fill == 4'(STAGES)); // RULE14 RULE21

  // -----------------------------------------------------------------
  // two-phase generator and shift controller
  // -----------------------------------------------------------------
  input_front_pkg::ctl_state_t state, next_state;
  logic [W-1:0] sreg      [STAGES];
  logic [W-1:0] next_sreg [STAGES];
  logic [3:0]   steps, next_steps;
  logic         ph_main, next_ph_main, ph_shift, next_ph_shift;
  logic         capture, next_capture;
  localparam int ADDR_W_L = input_front_pkg::ADDR_W;
  logic [ADDR_W_L-1:0] addr, next_addr;
  logic         valid, next_valid;
  logic [3:0]   target;

  // zero length code means the full eight bits
  assign target = (cfg.word_length == input_front_pkg::LEN_ZERO) ? 4'(W)
                                                                 : {1'b0, cfg.word_length}; // RULE3

  always_comb begin
    next_state    = state;
    next_steps    = steps;
    next_capture  = 1'b0;
    next_valid    = 1'b0;
    next_addr     = addr;
    // phases only from master clock edges, never both high
    next_ph_main  = mclk_rise ? 1'b1 : (mclk_fall ? 1'b0 : ph_main); // RULE17 RULE2
    next_ph_shift = mclk_fall & ~programming_supply; // RULE16 RULE17
    for (int i = 0; i < STAGES; i++) begin
      next_sreg[i] = sreg[i];
    end
    case (state)
      input_front_pkg::ST_IDLE: begin
        if (load_rise && all_loaded) begin // RULE6 RULE14
          next_state   = input_front_pkg::ST_CAPTURE;
          next_capture = 1'b1;
        end
      end
      input_front_pkg::ST_CAPTURE: begin
        for (int i = 0; i < STAGES; i++) begin
          next_sreg[i] = latch[i]; // RULE15
        end
        next_steps = 4'h0;
        next_state = input_front_pkg::ST_SHIFT;
      end
      input_front_pkg::ST_SHIFT: begin
        if (ph_shift | capture) begin // RULE16 RULE15
          for (int i = 0; i < STAGES; i++) begin
            next_addr[i] = sreg[i][0]; // RULE1 RULE18
            next_sreg[i] = {1'b0, sreg[i][W-1:1]};
          end
          next_steps = steps + 4'h1;
          if (steps + 4'h1 == target) begin // RULE22
            next_state = input_front_pkg::ST_DONE;
          end
        end
      end
      input_front_pkg::ST_DONE: begin
        next_valid = 1'b1; // RULE10
        next_state = input_front_pkg::ST_IDLE;
      end
      default: next_state = input_front_pkg::ST_IDLE;
    endcase
    if (programming_supply) begin
      for (int i = 0; i < STAGES; i++) begin
        next_addr[i] = latch[i][0]; // RULE19
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      state    <= input_front_pkg::ST_IDLE;
      steps    <= 4'h0;
      capture  <= 1'b0;
      valid    <= 1'b0;
      addr     <= '0;
      ph_main  <= 1'b0;
      ph_shift <= 1'b0;
      for (int i = 0; i < STAGES; i++) begin
        sreg[i] <= '0;
      end
    end else begin
      state    <= next_state;
      steps    <= next_steps;
      capture  <= next_capture;
      valid    <= next_valid;
      addr     <= next_addr;
      ph_main  <= next_ph_main;
      ph_shift <= next_ph_shift;
      for (int i = 0; i < STAGES; i++) begin
        sreg[i] <= next_sreg[i];
      end
    end
  end

  // -----------------------------------------------------------------
  // outputs
  // -----------------------------------------------------------------
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      memory_address      <= '0;
      memory_write_permit <= 1'b0;
      main_phase          <= 1'b0;
      shift_phase         <= 1'b0;
      arith_signed        <= 1'b0;
      sign_fill           <= 1'b0;
      data_valid          <= 1'b0;
      out_bus             <= '0;
      out_bus_oe          <= '0;
      window_latch_last   <= 1'b0;
      window_latch_middle <= 1'b0;
      window_latch_first  <= 1'b0;
    end else begin
      memory_address      <= addr; // RULE1
      memory_write_permit <= programming_supply; // RULE19
      main_phase          <= ph_main; // RULE17
      shift_phase         <= ph_shift | capture | programming_supply; // RULE16
      arith_signed        <= cfg.signed_data; // RULE8
      // sign extension only matters for words shorter than eight bits
      sign_fill           <= (target < 4'(W)) & cfg.signed_coeffs; // RULE11
      data_valid          <= valid; // RULE10
      out_bus             <= output_enable ? result_in : '0; // RULE9
      out_bus_oe          <= {input_front_pkg::OUT_W{output_enable}}; // RULE9
      window_latch_last   <= |latch[input_front_pkg::LAST_STAGE];
      window_latch_middle <= |latch[input_front_pkg::MIDDLE_STAGE];
      window_latch_first  <= |latch[input_front_pkg::FIRST_STAGE];
    end
  end

  // -----------------------------------------------------------------
  // checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  strobe_shift_a: assert property (strobe_rise |=> latch[0] == $past(latch[1]))  // RULE14
    else $error("chain did not shift toward stage zero");
  hold_latch_a: assert property (!strobe_rise |=> latch[4] == $past(latch[4]))  // RULE12
    else $error("latch changed without strobe");
  path_select_a: assert property (strobe_rise && cfg.input_path_select  // RULE13
                                  |=> latch[S_ST] == $past(data_in.s_word))
    else $error("parallel port not taken");
  load_start_a: assert property (load_rise && all_loaded  // RULE6
                                 && state == input_front_pkg::ST_IDLE
                                 |=> state == input_front_pkg::ST_CAPTURE ##1
                                     state == input_front_pkg::ST_SHIFT)
    else $error("load did not start conversion");
  phase_overlap_a: assert property (!(ph_main && ph_shift))  // RULE17
    else $error("phases overlap");
  valid_pulse_a: assert property (state == input_front_pkg::ST_DONE |=> ##1 data_valid)  // RULE10
    else $error("data valid missing");
  bus_enable_a: assert property (!output_enable |=> out_bus_oe == '0)  // RULE9
    else $error("bus driven while disabled");
  prog_route_a: assert property (programming_supply |=> memory_write_permit)  // RULE19
    else $error("program enable missing");
  no_early_a: assert property (state == input_front_pkg::ST_SHIFT && steps + 4'h1 < target  // RULE22
                               |=> state != input_front_pkg::ST_DONE)
    else $error("ended before word length");
  addr_drive_a: assert property (1'b1 |=> memory_address == $past(addr))  // RULE18
    else $error("address driver does not follow address latch");
  addr_shift_a: assert property (state == input_front_pkg::ST_SHIFT && ph_shift  // RULE1
                                 && !programming_supply |=> addr[0] == $past(sreg[0][0]))
    else $error("address bit not taken from serial register");
  word_len_a: assert property (state == input_front_pkg::ST_SHIFT |-> steps < target)  // RULE22
    else $error("shift count passed word length");
  sign_len_a: assert property (cfg.word_length == input_front_pkg::LEN_ZERO  // RULE11
                               |=> !sign_fill)
    else $error("sign fill set for full length words");
  arith_mode_a: assert property (1'b1 |=> arith_signed == $past(cfg.signed_data))  // RULE8
    else $error("arithmetic mode not following input");
  bus_drive_a: assert property (output_enable |=> out_bus == $past(result_in))  // RULE9
    else $error("bus not driven while enabled");
  bus_quiet_a: assert property (!output_enable |=> out_bus == '0)  // RULE9
    else $error("bus data while disabled");
  prog_addr_a: assert property (programming_supply |=> addr[0] == $past(latch[0][0]))  // RULE19
    else $error("programming address not routed");
  load_refuse_a: assert property (state == input_front_pkg::ST_IDLE && !all_loaded  // RULE14
                                  && load_rise |=> state == input_front_pkg::ST_IDLE)
    else $error("conversion started before chain loaded");
  shift_gate_a: assert property (programming_supply |=> !ph_shift)  // RULE16
    else $error("shift phase runs while programming");
  valid_once_a: assert property (data_valid |=> !data_valid)  // RULE10
    else $error("data valid longer than one cycle");
  capture_load_a: assert property (state == input_front_pkg::ST_CAPTURE  // RULE15
                                   |=> sreg[0] == $past(latch[0]))
    else $error("serial register not loaded on capture");
  main_rise_a: assert property (mclk_rise |=> ph_main)  // RULE17
    else $error("main phase missed master rise");
  main_fall_a: assert property (mclk_fall |=> !ph_main)  // RULE17
    else $error("main phase missed master fall");
  shift_fall_a: assert property (mclk_fall && !programming_supply |=> ph_shift)  // RULE17
    else $error("shift phase missed master fall");
  idle_hold_a: assert property (state == input_front_pkg::ST_IDLE  // RULE18
                                && !programming_supply |=> addr == $past(addr))
    else $error("address moved while idle");
  permit_drop_a: assert property (!programming_supply |=> !memory_write_permit)  // RULE19
    else $error("program enable without programming level");
  strobe_entry_a: assert property (strobe_rise  // RULE7
                                   |=> latch[STAGES-1] == $past(data_in.p_word))
    else $error("first stage did not capture input");

  conv_c: cover property (state == input_front_pkg::ST_DONE);
  par_c: cover property (strobe_rise && cfg.input_path_select);
  ser_c: cover property (strobe_rise && !cfg.input_path_select);
  prog_c: cover property (programming_supply);
  refuse_c: cover property (load_rise && !all_loaded);
endmodule

// file: testbench/pixel_source.sv
`timescale 1ns/10ps
module pixel_source (
  input  wire logic                        sys_clk,
  output logic                             master_clock,
  output logic                             strobe,
  output input_front_pkg::in_words_t       data_in
);
  // ----------------------------------------------------------------
  // master clock
  // ----------------------------------------------------------------
  // 10 mhz square wave, free running, half the permitted ceiling
  initial begin
    master_clock = 1'h0;
    strobe = 1'h0;
    data_in = '0;
    forever begin
      repeat (5) @(posedge sys_clk);
      #1 master_clock = ~master_clock;
    end
  end
  // ----------------------------------------------------------------
  // word delivery
  // ----------------------------------------------------------------
  // data is only valid around the strobe; afterwards it flips so a
  // latch that keeps following the lines is caught
  task automatic push(input input_front_pkg::in_words_t w);
    @(posedge sys_clk);
    #1 data_in = w;
    strobe = 1'h1;
    @(posedge sys_clk);
    #1 strobe = 1'h0;
    @(posedge sys_clk);
    #1 data_in = ~w;
  endtask
endmodule

// file: testbench/testbench.sv
`timescale 1ns/10ps
module testbench;
  logic                              sys_clk;
  logic                              rst_b;
  logic                              load;
  logic                              programming_supply;
  logic                              output_enable;
  logic                              master_clock;
  logic                              strobe;
  logic                              hit;
  logic                              memory_write_permit;
  logic                              main_phase;
  logic                              shift_phase;
  logic [8:0]                        exp_addr;
  int                                main_high;
  int                                shift_high;
  logic                              arith_signed;
  logic                              sign_fill;
  logic                              data_valid;
  logic                              window_latch_last;
  logic                              window_latch_middle;
  logic                              window_latch_first;
  logic [8:0]                        memory_address;
  logic [input_front_pkg::OUT_W-1:0] result_in;
  logic [input_front_pkg::OUT_W-1:0] out_bus;
  logic [input_front_pkg::OUT_W-1:0] out_bus_oe;
  logic [7:0]                        stg [9];
  input_front_pkg::in_words_t        data_in;
  input_front_pkg::config_t          cfg;
  int                                n_mismatch;
  int                                check_count;

  input_front dut_u (
    .sys_clk(sys_clk), .rst_b(rst_b), .data_in(data_in), .strobe(strobe), .load(load),
    .master_clock(master_clock), .cfg(cfg), .programming_supply(programming_supply),
    .output_enable(output_enable), .result_in(result_in), .memory_address(memory_address),
    .memory_write_permit(memory_write_permit),
    .main_phase(main_phase), .shift_phase(shift_phase),
    .arith_signed(arith_signed), .sign_fill(sign_fill), .data_valid(data_valid),
    .out_bus(out_bus), .out_bus_oe(out_bus_oe), .window_latch_last(window_latch_last),
    .window_latch_middle(window_latch_middle), .window_latch_first(window_latch_first)
  );
  pixel_source src_u (
    .sys_clk(sys_clk), .master_clock(master_clock), .strobe(strobe), .data_in(data_in)
  );

  initial begin
    sys_clk = 1'h0;
    forever #5 sys_clk = ~sys_clk;
  end
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  task automatic step;
    @(posedge sys_clk);
    #1;
  endtask
  task automatic tick;
    @(posedge sys_clk);
    #2;
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  task automatic hang;
    n_mismatch++;
    tally_and_finish;
  endtask
  task automatic chk(input logic [19:0] got, input logic [19:0] exp);
    check_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    chk({19'h0, got}, {19'h0, exp});
  endtask
  // expected chain moves toward stage zero on every strobe
  task automatic put(input logic [7:0] s, input logic [7:0] t, input logic [7:0] p);
    for (int i = 0; i < 8; i++) stg[i] = stg[i+1];
    stg[8] = p;
    if (cfg.input_path_select) begin
      stg[5] = t;
      stg[2] = s;
    end
    src_u.push({s, t, p});
    tick;
    tick;
    chk1(window_latch_first, |stg[8]);
    chk1(window_latch_middle, |stg[7]);
    chk1(window_latch_last, |stg[0]);
  endtask
  task automatic go;
    step;
    load = 1'h1;
    step;
    load = 1'h0;
  endtask
  // data is chosen so that successive addresses always differ
  task automatic convert(input int len);
    logic [8:0] e;
    logic [8:0] prev;
    int         n;
    prev = memory_address;
    go;
    for (int b = 0; b < len; b++) begin
      for (int i = 0; i < 9; i++) e[i] = stg[i][b];
      n = 0;
      while (memory_address === prev) begin
        tick;
        n++;
        if (n > 60) hang;
      end
      chk({11'h0, memory_address}, {11'h0, e});
      prev = memory_address;
    end
    n = 0;
    while (data_valid !== 1'h1) begin
      tick;
      n++;
      if (n > 60) hang;
    end
    tick;
    chk1(data_valid, 1'h0);
    repeat (15) tick;
    chk({11'h0, memory_address}, {11'h0, e});
  endtask
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    rst_b = 1'h0;
    load = 1'h0;
    programming_supply = 1'h0;
    output_enable = 1'h0;
    result_in = 20'h1_2345;
    cfg = '0;
    n_mismatch = 0;
    check_count = 0;
    for (int i = 0; i < 9; i++) stg[i] = 8'h00;
    repeat (5) @(posedge sys_clk);
    #1 rst_b = 1'h1;
    tick;
    chk1(data_valid, 1'h0);
    chk1(memory_write_permit, 1'h0);
    step;
    output_enable = 1'h1;
    tick;
    tick;
    chk(out_bus_oe, 20'hf_ffff);
    chk(out_bus, 20'h1_2345);
    step;
    output_enable = 1'h0;
    tick;
    tick;
    chk(out_bus_oe, 20'h0_0000);
    for (int k = 0; k < 2; k++) begin
      step;
      cfg.signed_data = k[0];
      cfg.signed_coeffs = ~k[0];
      cfg.word_length = 3'h3;
      tick;
      tick;
      chk1(arith_signed, k[0]);
      chk1(sign_fill, ~k[0]);
    end
    step;
    cfg.word_length = 3'h0;
    // serial fill; side ports carry junk that must be ignored
    for (int i = 0; i < 9; i++) begin
      put(8'hff, 8'hff, 8'h01 << (i % 8));
      if (i == 0) begin
        go;
        hit = 1'h0;
        repeat (40) begin
          tick;
          if (data_valid === 1'h1) hit = 1'h1;
        end
        chk1(hit, 1'h0);
      end
    end
    convert(8);
    step;
    cfg.word_length = 3'h3;
    convert(3);
    step;
    cfg.word_length = 3'h0;
    cfg.input_path_select = 1'h1;
    put(8'h00, 8'h00, 8'h80);
    put(8'h01, 8'h08, 8'h40);
    put(8'h02, 8'h10, 8'h80);
    put(8'h04, 8'h20, 8'h01);
    convert(8);
    step;
    programming_supply = 1'h1;
    tick;
    tick;
    chk1(memory_write_permit, 1'h1);
    for (int i = 0; i < 9; i++) exp_addr[i] = stg[i][0];
    chk({11'h0, memory_address}, {11'h0, exp_addr});
    main_high = 0;
    shift_high = 0;
    repeat (10) begin
      tick;
      if (main_phase === 1'h1) main_high++;
      if (shift_phase === 1'h1) shift_high++;
    end
    chk(main_high[19:0], 20'h0_0005);
    chk(shift_high[19:0], 20'h0_000a);
    step;
    programming_supply = 1'h0;
    tick;
    tick;
    chk1(memory_write_permit, 1'h0);
    shift_high = 0;
    repeat (10) begin
      tick;
      if (shift_phase === 1'h1) shift_high++;
    end
    chk(shift_high[19:0], 20'h0_0001);
    tally_and_finish;
  end
endmodule
